// ===== core/rvip_pkg.sv
// reset vector and interrupt priority: shared constants, types and helpers
// assumes one system clock; straps and flash security are steady across reset
//
// Functional notes
// R1: higher priority level always wins over lower
// R2: equal level: smallest vector number wins
// R3: vector address is base plus two words per vector number
// R4: core exceptions vectors 2-5 fixed level 3
// R5: debug events programmable level 1 to 3
// R6: low-voltage vector 20, level 0 to 2
// R7: reset addresses may overlay vector entries 0,1
// R8: internal or 20-bit boot: 020000/020002
// R9: 16-bit external boot: 000000/000002
// R10: bus-width strap 0=16-bit, 1=20-bit
// R11: secured flash forces internal boot
// R12: map select resets to strap only unsecured
// R13: one registered winner, recomputed every cycle
package rvip_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_VEC = 21;
  localparam int unsigned VEC_W = 5;
  localparam int unsigned LVL_W = 2;
  localparam int unsigned ADDR_W = 21;
  localparam int unsigned NUM_DBG = 5;
  localparam int unsigned NUM_PROG = 3;

  // ---------------------------------------------------------------
  // fetch addresses (program words)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] BOOT_INT_ADDR = 21'h02_0000;
  localparam logic [ADDR_W-1:0] WDOG_INT_ADDR = 21'h02_0002;
  localparam logic [ADDR_W-1:0] BOOT_EXT16_ADDR = 21'h00_0000;
  localparam logic [ADDR_W-1:0] WDOG_EXT16_ADDR = 21'h00_0002;
  localparam logic [ADDR_W-1:0] VEC_BASE_RST = 21'h00_0000;
  localparam logic [ADDR_W-1:0] VEC_STRIDE = 21'h00_0002;

  // ---------------------------------------------------------------
  // levels and level codes
  // ---------------------------------------------------------------
  localparam logic [LVL_W-1:0] LVL_0 = 2'h0;
  localparam logic [LVL_W-1:0] LVL_1 = 2'h1;
  localparam logic [LVL_W-1:0] LVL_2 = 2'h2;
  localparam logic [LVL_W-1:0] LVL_3 = 2'h3;
  // debug code 0 and peripheral code 3 mean disabled
  localparam logic [LVL_W-1:0] DBG_OFF_CODE = 2'h0;
  localparam logic [LVL_W-1:0] PROG_OFF_CODE = 2'h3;

  // vector classes
  typedef enum {
    RVIP_VC_NONE,
    RVIP_VC_FIX3,
    RVIP_VC_FIX2,
    RVIP_VC_FIX1,
    RVIP_VC_FIX0,
    RVIP_VC_DBG,
    RVIP_VC_PROG
  } rvip_vclass_t;

  // class of each vector number
  function automatic rvip_vclass_t vec_class(input int unsigned v);
    unique case (v)
      2, 3, 4, 5: vec_class = RVIP_VC_FIX3; // R4
      6, 7, 9, 10, 11: vec_class = RVIP_VC_DBG; // R5
      14: vec_class = RVIP_VC_FIX2;
      15: vec_class = RVIP_VC_FIX1;
      16: vec_class = RVIP_VC_FIX0;
      17, 18, 20: vec_class = RVIP_VC_PROG; // R6
      default: vec_class = RVIP_VC_NONE; // reserved and overlay slots
    endcase
  endfunction

  // index of a debug vector into the debug level field
  function automatic int unsigned dbg_index(input int unsigned v);
    unique case (v)
      6: dbg_index = 0;
      7: dbg_index = 1;
      9: dbg_index = 2;
      10: dbg_index = 3;
      default: dbg_index = 4;
    endcase
  endfunction

  // index of a programmable vector: pin a, pin b, low-voltage
  function automatic int unsigned prog_index(input int unsigned v);
    unique case (v)
      17: prog_index = 0;
      18: prog_index = 1;
      default: prog_index = 2;
    endcase
  endfunction

endpackage

// ===== core/rvip_arb_if.sv
// carrier between the top and the priority ranking module
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface rvip_arb_if;
  logic [rvip_pkg::NUM_VEC-1:0] req;
  logic [rvip_pkg::NUM_VEC-1:0][rvip_pkg::LVL_W-1:0] lvl;
  logic found;
  logic [rvip_pkg::VEC_W-1:0] win;
  logic [rvip_pkg::LVL_W-1:0] win_lvl;

  modport top (output req, output lvl, input found, input win, input win_lvl);
  modport arb (input req, input lvl, output found, output win, output win_lvl);
endinterface

// ===== core/rvip_rank.sv
// priority ranking: picks one winner among enabled requests
// assumes requests and levels are already qualified by the top
`timescale 1ns/1ps
module rvip_rank (
  rvip_arb_if.arb a
);

  // ---------------------------------------------------------------
  // search
  // ---------------------------------------------------------------
  // ascending scan with strict compare keeps the smallest number on ties
  always_comb begin
    a.found = 1'b0;
    a.win = '0;
    a.win_lvl = '0;
    for (int unsigned i = 0; i < rvip_pkg::NUM_VEC; i++) begin
      if (a.req[i] && (!a.found || a.lvl[i] > a.win_lvl)) begin // R1 R2
        a.found = 1'b1;
        a.win = rvip_pkg::VEC_W'(i);
        a.win_lvl = a.lvl[i];
      end
    end
  end

endmodule

// ===== core/rvip_top.sv
// reset fetch address selection and interrupt vector arbitration
// assumes the core holds each pending line until it services it
`timescale 1ns/1ps
module rvip_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_bus_width_strap_i,
  input wire logic external_boot_strap_i,
  input wire logic flash_secured_i,
  input wire logic watchdog_reset_i,
  input wire logic map_wr_i,
  input wire logic map_wdata_i,
  input wire logic base_wr_i,
  input wire logic [rvip_pkg::ADDR_W-1:0] base_wdata_i,
  input wire logic [rvip_pkg::NUM_VEC-1:0] irq_pend_i,
  input wire logic [rvip_pkg::NUM_DBG*rvip_pkg::LVL_W-1:0] dbg_level_i,
  input wire logic [rvip_pkg::NUM_PROG*rvip_pkg::LVL_W-1:0] prog_level_i,
  output logic straps_valid_o,
  output logic [rvip_pkg::ADDR_W-1:0] reset_fetch_addr_o,
  output logic boot_map_select_o,
  output logic secured_at_reset_flag_o,
  output logic ext_map_active_o,
  output logic ext_addr_20bit_o,
  output logic [rvip_pkg::ADDR_W-1:0] vector_base_o,
  output logic irq_valid_o,
  output logic [rvip_pkg::VEC_W-1:0] irq_vector_o,
  output logic [rvip_pkg::LVL_W-1:0] irq_level_o,
  output logic [rvip_pkg::ADDR_W-1:0] irq_addr_o
);

  // ---------------------------------------------------------------
  // boot strap capture
  // ---------------------------------------------------------------
  logic straps_valid_r;
  logic secured_r;
  logic sec_boot;
  logic map_wr_ok;
  logic map_sel_r;
  logic map_sel_nxt;
  logic ext_boot;
  logic [rvip_pkg::ADDR_W-1:0] fetch_nxt;

  // secured flash blocks external boot whatever the strap says
  assign ext_boot = external_boot_strap_i & ~flash_secured_i; // R11 R12

  // straps are taken on the first edge after reset release
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      straps_valid_r <= 1'b0;
    end else begin
      straps_valid_r <= 1'b1;
    end
  end

  // secured state, latched on_chip_debug_unit at capture
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      secured_r <= 1'b0;
    end else if (!straps_valid_r) begin
      secured_r <= flash_secured_i; // R11
    end
  end

  // secured state as the map sees it: live at capture, latched after
  assign sec_boot = !straps_valid_r ? flash_secured_i : secured_r; // R11

  // software writes count only on_chip_debug_unit the straps are in
  assign map_wr_ok = straps_valid_r & map_wr_i;

  // map select: strap at boot, 0 if flash is secured; software writes afterwards
  assign map_sel_nxt = !straps_valid_r ? ext_boot : // R12
    (map_wr_ok ? map_wdata_i : map_sel_r);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      map_sel_r <= 1'b0;
    end else begin
      map_sel_r <= map_sel_nxt;
    end
  end

  // ---------------------------------------------------------------
  // reset fetch address
  // ---------------------------------------------------------------
  logic use_ext16;
  logic bus20_nxt;
  logic [rvip_pkg::ADDR_W-1:0] fetch_ext16;
  logic [rvip_pkg::ADDR_W-1:0] fetch_int;

  // only external boot with the narrow bus starts at the bottom
  assign use_ext16 = ext_boot & ~ext_bus_width_strap_i; // R9 R10
  assign bus20_nxt = ext_boot & ext_bus_width_strap_i;

  // narrow-bus external boot starts at the bottom of program space
  assign fetch_ext16 = watchdog_reset_i ? rvip_pkg::WDOG_EXT16_ADDR : // R9
    rvip_pkg::BOOT_EXT16_ADDR;

  // internal boot and wide-bus external boot share the boot window
  assign fetch_int = watchdog_reset_i ? rvip_pkg::WDOG_INT_ADDR : // R8
    rvip_pkg::BOOT_INT_ADDR;

  // the low fetch addresses sit on vector slots 0 and 1 when base is zero
  assign fetch_nxt = use_ext16 ? fetch_ext16 : fetch_int; // R7

  // boot outputs settle on the capture edge and then hold
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_fetch_addr_o <= rvip_pkg::BOOT_INT_ADDR;
      ext_addr_20bit_o <= 1'b0;
    end else if (!straps_valid_r) begin
      reset_fetch_addr_o <= fetch_nxt; // R8 R9
      ext_addr_20bit_o <= bus20_nxt;
    end
  end

  // capture flag and the secured-at-boot flag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      straps_valid_o <= 1'b0;
      secured_at_reset_flag_o <= 1'b0;
    end else begin
      straps_valid_o <= 1'b1;
      secured_at_reset_flag_o <= sec_boot; // R11
    end
  end

  // map select and the map that it really enables
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_map_select_o <= 1'b0;
      ext_map_active_o <= 1'b0;
    end else begin
      boot_map_select_o <= map_sel_nxt; // R12
      // writing the select has no effect on the map if secured at boot
      ext_map_active_o <= map_sel_nxt & ~sec_boot; // R11
    end
  end

  // ---------------------------------------------------------------
  // vector base
  // ---------------------------------------------------------------
  logic [rvip_pkg::ADDR_W-1:0] base_r;

  // software may move the table at any time
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      base_r <= rvip_pkg::VEC_BASE_RST;
    end else if (base_wr_i) begin
      base_r <= base_wdata_i;
    end
  end

  // base as the core sees it
  assign vector_base_o = base_r;

  // ---------------------------------------------------------------
  // level qualification per vector
  // ---------------------------------------------------------------
  // qualified requests and the ranker's answer
  rvip_arb_if arb ();

  // effective level of a vector, and whether it may compete
  function automatic logic [rvip_pkg::LVL_W:0] eff_level(
    input int unsigned v,
    input logic [rvip_pkg::NUM_DBG*rvip_pkg::LVL_W-1:0] dbg,
    input logic [rvip_pkg::NUM_PROG*rvip_pkg::LVL_W-1:0] prg
  );
    logic [rvip_pkg::LVL_W-1:0] code;
    code = '0;
    unique case (rvip_pkg::vec_class(v))
      rvip_pkg::RVIP_VC_FIX3: eff_level = {1'b1, rvip_pkg::LVL_3}; // R4
      rvip_pkg::RVIP_VC_FIX2: eff_level = {1'b1, rvip_pkg::LVL_2};
      rvip_pkg::RVIP_VC_FIX1: eff_level = {1'b1, rvip_pkg::LVL_1};
      rvip_pkg::RVIP_VC_FIX0: eff_level = {1'b1, rvip_pkg::LVL_0};
      rvip_pkg::RVIP_VC_DBG: begin
        code = dbg[rvip_pkg::dbg_index(v)*rvip_pkg::LVL_W +: rvip_pkg::LVL_W];
        eff_level = {code != rvip_pkg::DBG_OFF_CODE, code}; // R5
      end
      rvip_pkg::RVIP_VC_PROG: begin
        code = prg[rvip_pkg::prog_index(v)*rvip_pkg::LVL_W +: rvip_pkg::LVL_W];
        eff_level = {code != rvip_pkg::PROG_OFF_CODE, code}; // R6
      end
      default: eff_level = '0;
    endcase
  endfunction

  // requests enter the ranker only when enabled at a legal level
  for (genvar g = 0; g < rvip_pkg::NUM_VEC; g++) begin : g_qual
    logic [rvip_pkg::LVL_W:0] el;
    logic enabled;
    assign el = eff_level(g, dbg_level_i, prog_level_i);
    // top bit of the effective level says the source may compete
    assign enabled = el[rvip_pkg::LVL_W];
    assign arb.req[g] = irq_pend_i[g] & enabled; // R5 R6
    assign arb.lvl[g] = el[rvip_pkg::LVL_W-1:0];
  end

  // one winner per cycle over all qualified requests
  rvip_rank u_rank (
    .a(arb)
  );

  // ---------------------------------------------------------------
  // vector address and registered answer
  // ---------------------------------------------------------------
  logic [rvip_pkg::ADDR_W-1:0] win_addr;
  logic [rvip_pkg::ADDR_W-1:0] vec_offset;

  // each vector number sits two program words above the one before
  assign vec_offset = rvip_pkg::ADDR_W'(arb.win) * rvip_pkg::VEC_STRIDE; // R3

  // table entry of the winner
  assign win_addr = base_r + vec_offset; // R3

  // winner re-evaluated on every edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_valid_o <= 1'b0;
      irq_vector_o <= '0;
      irq_level_o <= '0;
      irq_addr_o <= rvip_pkg::VEC_BASE_RST;
    end else begin
      irq_valid_o <= arb.found; // R13
      irq_vector_o <= arb.win;
      irq_level_o <= arb.win_lvl;
      irq_addr_o <= win_addr;
    end
  end

endmodule

// ===== tb/rvip_top_properties.sv
// checker: boot capture and ranking relations at the top ports
// assumes one clock domain, reset active high
`timescale 1ns/1ps
module rvip_top_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_bus_width_strap_i,
  input wire logic external_boot_strap_i,
  input wire logic flash_secured_i,
  input wire logic watchdog_reset_i,
  input wire logic [rvip_pkg::NUM_VEC-1:0] irq_pend_i,
  input wire logic straps_valid_o,
  input wire logic [rvip_pkg::ADDR_W-1:0] reset_fetch_addr_o,
  input wire logic boot_map_select_o,
  input wire logic secured_at_reset_flag_o,
  input wire logic ext_map_active_o,
  input wire logic ext_addr_20bit_o,
  input wire logic [rvip_pkg::ADDR_W-1:0] vector_base_o,
  input wire logic irq_valid_o,
  input wire logic [rvip_pkg::VEC_W-1:0] irq_vector_o,
  input wire logic [rvip_pkg::LVL_W-1:0] irq_level_o,
  input wire logic [rvip_pkg::ADDR_W-1:0] irq_addr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // expected capture values worked out from the straps
  wire ext_w = external_boot_strap_i & ~flash_secured_i;
  wire [20:0] fetch_w = (ext_w & ~ext_bus_width_strap_i) ? {19'h0, watchdog_reset_i, 1'h0}
    : {3'h0, 1'h1, 15'h0, watchdog_reset_i, 1'h0};
  sequence s_cap;
    $rose(straps_valid_o);
  endsequence
  property p_boot; s_cap |-> reset_fetch_addr_o == $past(fetch_w); endproperty
  a_boot: assert property (p_boot) else $error("boot fetch address");
  property p_width; s_cap |-> ext_addr_20bit_o == $past(ext_w & ext_bus_width_strap_i); endproperty
  a_width: assert property (p_width) else $error("bus width");
  property p_map; s_cap |-> boot_map_select_o == $past(ext_w); endproperty
  a_map: assert property (p_map) else $error("map select at boot");
  property p_sec; straps_valid_o && secured_at_reset_flag_o |-> !ext_map_active_o; endproperty
  a_sec: assert property (p_sec) else $error("secured external map");
  property p_fix3;
    |irq_pend_i[5:2] |=> irq_level_o == 2'h3 && irq_vector_o >= 5'h02 && irq_vector_o <= 5'h05;
  endproperty
  a_fix3: assert property (p_fix3) else $error("core exception rank");
  property p_low; irq_pend_i[3] && !irq_pend_i[2] |=> irq_vector_o == 5'h03; endproperty
  a_low: assert property (p_low) else $error("lowest vector");
  property p_addr;
    irq_valid_o |-> irq_addr_o == $past(vector_base_o) + {15'h0, irq_vector_o, 1'h0};
  endproperty
  a_addr: assert property (p_addr) else $error("vector address");
  property p_none; irq_pend_i == 21'h0 |=> !irq_valid_o; endproperty
  a_none: assert property (p_none) else $error("valid without request");
endmodule
bind rvip_top rvip_top_properties rvip_top_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
  .ext_bus_width_strap_i(ext_bus_width_strap_i), .external_boot_strap_i(external_boot_strap_i),
  .flash_secured_i(flash_secured_i), .watchdog_reset_i(watchdog_reset_i),
  .irq_pend_i(irq_pend_i), .straps_valid_o(straps_valid_o),
  .reset_fetch_addr_o(reset_fetch_addr_o), .boot_map_select_o(boot_map_select_o),
  .secured_at_reset_flag_o(secured_at_reset_flag_o), .ext_map_active_o(ext_map_active_o),
  .ext_addr_20bit_o(ext_addr_20bit_o), .vector_base_o(vector_base_o),
  .irq_valid_o(irq_valid_o), .irq_vector_o(irq_vector_o), .irq_level_o(irq_level_o),
  .irq_addr_o(irq_addr_o));

// ===== tb/rvip_core_model.sv
// core model: holds pending lines, retires the winning vector
// assumes winner outputs lag pending lines by one cycle
`timescale 1ns/1ps
module rvip_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [3:0] wait_i,
  input wire logic [20:0] set_i,
  input wire logic load_i,
  input wire logic irq_valid_i,
  input wire logic [4:0] irq_vector_i,
  input wire logic [20:0] irq_addr_i,
  output logic [20:0] pend_o,
  output logic taken_o,
  output logic [4:0] taken_vec_o,
  output logic [20:0] taken_addr_o
);
  logic [3:0] cnt_r;
  // take a winner, then skip the stale cycle plus the chosen delay
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_o <= 21'h0;
      cnt_r <= 4'h0;
      taken_o <= 1'h0;
    end else begin
      taken_o <= 1'h0;
      if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
      if (load_i) pend_o <= set_i;
      else if (en_i && irq_valid_i && cnt_r == 4'h0) begin
        pend_o <= (pend_o | set_i) & ~(21'h1 << irq_vector_i);
        taken_o <= 1'h1;
        taken_vec_o <= irq_vector_i;
        taken_addr_o <= irq_addr_i;
        cnt_r <= wait_i + 4'h1;
      end else pend_o <= pend_o | set_i;
    end
  end
endmodule

// ===== tb/tb_top.sv
// testbench: strap capture, priority ranking, core retirement
// assumes the package, design and core model are compiled first
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'h0, rst_i = 1'h1, bw = 1'h0, eb = 1'h0, sec = 1'h0, wd = 1'h0, mwd = 1'h0;
  logic mwr = 1'h0, bwr = 1'h0, en = 1'h0, ld = 1'h1, sv, map, secf, xmap, w20, ival, tk;
  logic [20:0] bwd = 21'h0, set = 21'h0, pend, fetch, vbase, iaddr, taddr;
  logic [9:0] dbg = 10'h0;
  logic [5:0] prg = 6'h3f;
  logic [3:0] wt = 4'h0;
  logic [4:0] ivec, tvec;
  logic [1:0] ilvl;
  int error_cnt = 0, check_count = 0;
  initial forever #2 clk_i = ~clk_i;
  rvip_top rvip_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ext_bus_width_strap_i(bw),
    .external_boot_strap_i(eb), .flash_secured_i(sec), .watchdog_reset_i(wd),
    .map_wr_i(mwr), .map_wdata_i(mwd), .base_wr_i(bwr), .base_wdata_i(bwd),
    .irq_pend_i(pend), .dbg_level_i(dbg), .prog_level_i(prg), .straps_valid_o(sv),
    .reset_fetch_addr_o(fetch), .boot_map_select_o(map), .secured_at_reset_flag_o(secf),
    .ext_map_active_o(xmap), .ext_addr_20bit_o(w20), .vector_base_o(vbase),
    .irq_valid_o(ival), .irq_vector_o(ivec), .irq_level_o(ilvl), .irq_addr_o(iaddr));
  rvip_core_model rvip_core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .en_i(en),
    .wait_i(wt), .set_i(set), .load_i(ld), .irq_valid_i(ival), .irq_vector_i(ivec),
    .irq_addr_i(iaddr), .pend_o(pend), .taken_o(tk), .taken_vec_o(tvec), .taken_addr_o(taddr));
  // compare one value and count it
  task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // every strap combination, then a map write after capture
  task automatic t_boot;
    logic x;
    for (int i = 0; i < 16; i++) begin
      {bw, eb, sec, wd} = 4'(i);
      rst_i = 1'h1;
      cyc(8);
      chk(21'(sv), 21'h0, "capture before release");
      rst_i = 1'h0;
      cyc(1);
      x = eb & ~sec;
      chk(21'(sv), 21'h1, "capture after release");
      chk(fetch, (x & ~bw) ? {19'h0, wd, 1'h0} : {3'h0, 1'h1, 15'h0, wd, 1'h0}, "fetch");
      chk(21'(w20), 21'(x & bw), "bus width");
      chk(21'({map, secf}), 21'({x, sec}), "map at boot");
      mwr = 1'h1;
      mwd = !wd;
      cyc(1);
      mwr = 1'h0;
      cyc(1);
      chk(21'(map), 21'(mwd), "map write");
      chk(21'(xmap), 21'(mwd & !sec), "external map");
    end
    $display("test boot done");
  endtask
  // level and vector ordering across classes after a base move
  task automatic t_rank;
    logic [20:0] p[8] = '{21'h020010, 21'h000240, 21'h000240, 21'h110000, 21'h108000,
      21'h000040, 21'h180101, 21'h020800};
    logic [9:0] d[8] = '{10'h0, 10'h031, 10'h022, 10'h0, 10'h0, 10'h0, 10'h0, 10'h0};
    logic [5:0] g[8] = '{6'h3e, 6'h3f, 6'h3f, 6'h0f, 6'h2f, 6'h3f, 6'h3f, 6'h3c};
    logic [4:0] v[8] = '{5'h04, 5'h09, 5'h06, 5'h10, 5'h14, 5'h1f, 5'h1f, 5'h11};
    logic [1:0] l[8] = '{2'h3, 2'h3, 2'h2, 2'h0, 2'h2, 2'h0, 2'h0, 2'h0};
    bwr = 1'h1;
    bwd = 21'h010000;
    cyc(1);
    bwr = 1'h0;
    chk(vbase, 21'h010000, "base");
    for (int i = 0; i < 8; i++) begin
      set = p[i];
      dbg = d[i];
      prg = g[i];
      cyc(2);
      chk(21'(ival), 21'(v[i] != 5'h1f), "valid");
      if (v[i] != 5'h1f) begin
        chk(21'(ivec), 21'(v[i]), "vector");
        chk(21'(ilvl), 21'(l[i]), "level");
        chk(iaddr, 21'h010000 + {15'h0, v[i], 1'h0}, "address");
      end
    end
    $display("test rank done");
  endtask
  // four lines retired in rank order by a prompt or slow core
  task automatic t_core(input logic [3:0] w);
    logic [4:0] ord[4] = '{5'h03, 5'h05, 5'h0e, 5'h12};
    wt = w;
    prg = 6'h37;
    set = 21'h044028;
    cyc(3);
    ld = 1'h0;
    set = 21'h0;
    en = 1'h1;
    for (int k = 0; k < 4; k++) begin
      cyc(1);
      for (int n = 0; n < 40 && tk !== 1'h1; n++) cyc(1);
      chk(21'(tvec), 21'(ord[k]), "retire order");
      chk(taddr, 21'h010000 + {15'h0, ord[k], 1'h0}, "retire address");
    end
    en = 1'h0;
    ld = 1'h1;
    cyc(2);
    chk(21'(ival), 21'h0, "idle");
    $display("test core done");
  endtask
  initial begin
    t_boot;
    t_rank;
    t_core(4'h0);
    t_core(4'h5);
    results;
  end
  // watchdog well beyond the expected run length
  initial begin
    #50000;
    error_cnt++;
    results;
  end
endmodule
